// ---- status_output_router.sv ----
// Purpose: Route eight drive indications onto three output pairs
// Assumes: Indications come from logic on core_clk
// Notes:   Selection words take effect on restart_pulse
`timescale 1ns/1ps
module status_output_router
   import status_router_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              restart_pulse,
   input  wire status_ind_t       status_ind,
   output logic      [PAIR_N-1:0] io_connector
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   router_state_t state_reg;
   router_state_t state_next;
   logic [PAIR_N-1:0] drive_a;
   logic [PAIR_N-1:0] drive_b;
   logic [FIELD_N-1:0] ind_a;
   logic [FIELD_N-1:0] ind_b;

   assign ind_a = {status_ind.servo_ready,
                   status_ind.rotating,
                   status_ind.speed_match,
                   status_ind.position_done};
   assign ind_b = {status_ind.warning,
                   status_ind.brake_release,
                   status_ind.speed_limited,
                   status_ind.torque_limited};

   ////////////////////////////////////////////////////////////////////////////
   // Field decoders

   router_word_decoder u_decode_a (
      .select_word (state_reg.active_a),
      .ind         (ind_a),
      .pair_drive  (drive_a)
   );

   router_word_decoder u_decode_b (
      .select_word (state_reg.active_b),
      .ind         (ind_b),
      .pair_drive  (drive_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_next = state_reg;
      state_next.rd_data = 16'h0000;
      if (reg_write) begin
         if (reg_addr == OFS_SELECT_A) begin
            state_next.stored_a = reg_wdata;
         end
         if (reg_addr == OFS_SELECT_B) begin
            state_next.stored_b = reg_wdata;
         end
      end
      if (reg_read) begin
         unique case (reg_addr)
            OFS_SELECT_A: state_next.rd_data = state_reg.stored_a;
            OFS_SELECT_B: state_next.rd_data = state_reg.stored_b;
            OFS_PENDING:  state_next.rd_data = {15'h0000, (state_reg.stored_a != state_reg.active_a) ||
                                                         (state_reg.stored_b != state_reg.active_b)};
            OFS_ACTIVE_A: state_next.rd_data = state_reg.active_a;
            OFS_ACTIVE_B: state_next.rd_data = state_reg.active_b;
            default:      state_next.rd_data = 16'h0000;
         endcase
      end
      // Only a restart moves stored words into the routing
      if (restart_pulse) begin
         state_next.active_a = state_reg.stored_a;
         state_next.active_b = state_reg.stored_b;
      end
      state_next.pair_out = drive_a | drive_b;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.stored_a <= RESET_SELECT_A;
         state_reg.stored_b <= RESET_SELECT_B;
         state_reg.active_a <= RESET_SELECT_A;
         state_reg.active_b <= RESET_SELECT_B;
         state_reg.rd_data  <= 16'h0000;
         state_reg.pair_out <= 3'h0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata    = state_reg.rd_data;
   assign io_connector = state_reg.pair_out;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_pos_pair1;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD0 +: FIELD_W] == CODE_PAIR1 && status_ind.position_done)
      |=> io_connector[0];
   endproperty
   a_pos_pair1: assert property (p_pos_pair1) else $error("Position done missing on pair 1");

   property p_pos_reserved;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD0 +: FIELD_W] > CODE_PAIR3 &&
       state_reg.active_a[15:4] == 12'h000 && state_reg.active_b == 16'h0000)
      |=> io_connector == 3'h0;
   endproperty
   a_pos_reserved: assert property (p_pos_reserved) else $error("Reserved code drove a pair");

   property p_match_pair2;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD1 +: FIELD_W] == CODE_PAIR2 && status_ind.speed_match)
      |=> io_connector[1];
   endproperty
   a_match_pair2: assert property (p_match_pair2) else $error("Speed match missing on pair 2");

   property p_rot_pair3;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD2 +: FIELD_W] == CODE_PAIR3 && status_ind.rotating)
      |=> io_connector[2];
   endproperty
   a_rot_pair3: assert property (p_rot_pair3) else $error("Rotating missing on pair 3");

   property p_ready_pair1;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD3 +: FIELD_W] == CODE_PAIR1 && status_ind.servo_ready)
      |=> io_connector[0];
   endproperty
   a_ready_pair1: assert property (p_ready_pair1) else $error("Servo ready missing on pair 1");

   property p_all_disabled;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a == 16'h0000 && state_reg.active_b == 16'h0000)
      |=> io_connector == 3'h0;
   endproperty
   a_all_disabled: assert property (p_all_disabled) else $error("Disabled fields drove a pair");

   property p_torque_pair2;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_b[POS_FIELD0 +: FIELD_W] == CODE_PAIR2 && status_ind.torque_limited)
      |=> io_connector[1];
   endproperty
   a_torque_pair2: assert property (p_torque_pair2) else $error("Torque limit missing on pair 2");

   property p_pair_only_if_source;
      @(posedge core_clk) disable iff (!reset_n)
      (status_ind == 8'h00) |=> io_connector == 3'h0;
   endproperty
   a_pair_only_if_source: assert property (p_pair_only_if_source) else $error("Pair on with no source");

   property p_slimit_pair3;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_b[POS_FIELD1 +: FIELD_W] == CODE_PAIR3 && status_ind.speed_limited)
      |=> io_connector[2];
   endproperty
   a_slimit_pair3: assert property (p_slimit_pair3) else $error("Speed limit missing on pair 3");

   property p_brake_pair1;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_b[POS_FIELD2 +: FIELD_W] == CODE_PAIR1 && status_ind.brake_release)
      |=> io_connector[0];
   endproperty
   a_brake_pair1: assert property (p_brake_pair1) else $error("Brake missing on pair 1");

   property p_warn_pair2;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_b[POS_FIELD3 +: FIELD_W] == CODE_PAIR2 && status_ind.warning)
      |=> io_connector[1];
   endproperty
   a_warn_pair2: assert property (p_warn_pair2) else $error("Warning missing on pair 2");

   property p_hold_without_restart;
      @(posedge core_clk) disable iff (!reset_n)
      (!restart_pulse) |=> $stable(state_reg.active_a) && $stable(state_reg.active_b);
   endproperty
   a_hold_without_restart: assert property (p_hold_without_restart) else $error("Routing changed without restart");

   property p_restart_applies;
      @(posedge core_clk) disable iff (!reset_n)
      restart_pulse |=> state_reg.active_a == $past(state_reg.stored_a) &&
                        state_reg.active_b == $past(state_reg.stored_b);
   endproperty
   a_restart_applies: assert property (p_restart_applies) else $error("Restart did not apply words");

   property p_read_one_cycle;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == OFS_SELECT_B) ##1 !reg_read |=> reg_rdata == 16'h0000;
   endproperty
   a_read_one_cycle: assert property (p_read_one_cycle) else $error("Read data stood too long");

   property p_pos_disabled;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD0 +: FIELD_W] == CODE_DISABLED && status_ind == 8'h01)
      |=> io_connector == 3'h0;
   endproperty
   a_pos_disabled: assert property (p_pos_disabled) else $error("Disabled position field drove a pair");

   property p_pos_pair2;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD0 +: FIELD_W] == CODE_PAIR2 && status_ind.position_done)
      |=> io_connector[1];
   endproperty
   a_pos_pair2: assert property (p_pos_pair2) else $error("Position done missing on pair 2");

   property p_pos_pair3;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_a[POS_FIELD0 +: FIELD_W] == CODE_PAIR3 && status_ind.position_done)
      |=> io_connector[2];
   endproperty
   a_pos_pair3: assert property (p_pos_pair3) else $error("Position done missing on pair 3");

   property p_torque_off;
      @(posedge core_clk) disable iff (!reset_n)
      (state_reg.active_b[POS_FIELD0 +: FIELD_W] == CODE_DISABLED && status_ind == 8'h10)
      |=> io_connector == 3'h0;
   endproperty
   a_torque_off: assert property (p_torque_off) else $error("Disabled torque field drove a pair");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (!reset_n)
      (!reg_read) |=> reg_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without a read");

   property p_read_stored_a;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == OFS_SELECT_A) |=> reg_rdata == $past(state_reg.stored_a);
   endproperty
   a_read_stored_a: assert property (p_read_stored_a) else $error("Select A read wrong");

   property p_read_stored_b;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == OFS_SELECT_B) |=> reg_rdata == $past(state_reg.stored_b);
   endproperty
   a_read_stored_b: assert property (p_read_stored_b) else $error("Select B read wrong");

   property p_write_a_lands;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_write && reg_addr == OFS_SELECT_A) |=> state_reg.stored_a == $past(reg_wdata);
   endproperty
   a_write_a_lands: assert property (p_write_a_lands) else $error("Select A write lost");

   property p_write_b_lands;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_write && reg_addr == OFS_SELECT_B) |=> state_reg.stored_b == $past(reg_wdata);
   endproperty
   a_write_b_lands: assert property (p_write_b_lands) else $error("Select B write lost");

   property p_stored_hold;
      @(posedge core_clk) disable iff (!reset_n)
      (!reg_write) |=> $stable(state_reg.stored_a) && $stable(state_reg.stored_b);
   endproperty
   a_stored_hold: assert property (p_stored_hold) else $error("Stored word changed without write");

   property p_restart_sync;
      @(posedge core_clk) disable iff (!reset_n)
      (restart_pulse && !reg_write)
      |=> state_reg.active_a == state_reg.stored_a && state_reg.active_b == state_reg.stored_b;
   endproperty
   a_restart_sync: assert property (p_restart_sync) else $error("Restart left routing pending");

   ////////////////////////////////////////////////////////////////////////////
   // Coverage

   property p_cov_restart_change;
      @(posedge core_clk) disable iff (!reset_n)
      restart_pulse ##1 $changed(state_reg.active_a);
   endproperty
   c_cov_restart_change: cover property (p_cov_restart_change);

   property p_cov_all_pairs;
      @(posedge core_clk) disable iff (!reset_n)
      io_connector == 3'h7;
   endproperty
   c_cov_all_pairs: cover property (p_cov_all_pairs);

   property p_cov_write_read;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_write && reg_addr == OFS_SELECT_A) ##1 (reg_read && reg_addr == OFS_SELECT_A);
   endproperty
   c_cov_write_read: cover property (p_cov_write_read);

   property p_cov_brake_default;
      @(posedge core_clk) disable iff (!reset_n)
      status_ind.brake_release ##1 io_connector[0];
   endproperty
   c_cov_brake_default: cover property (p_cov_brake_default);

endmodule

// ---- status_router_pkg.sv ----
// Purpose: Constants and types for the status output router
// Assumes: One clock, plain register port, 16-bit registers
// Notes:   Behaviour list below
//
// Behaviour
// - Select-A field 0 routes position done
// - Select-A field 1 routes speed match
// - Select-A field 2 routes rotating
// - Select-A field 3 routes servo ready
// - Select-B field 0 routes torque limited
// - Select-B field 1 routes speed limited
// - Select-B fields 2,3 route brake, warning
package status_router_pkg;

   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 16;
   localparam int          FIELD_W         = 4;
   localparam int          PAIR_N          = 3;
   localparam int          FIELD_N         = 4;

   localparam logic [15:0] OFS_SELECT_A    = 16'h250e;
   localparam logic [15:0] OFS_SELECT_B    = 16'h250f;
   localparam logic [15:0] OFS_PENDING     = 16'h2600;
   localparam logic [15:0] OFS_ACTIVE_A    = 16'h2601;
   localparam logic [15:0] OFS_ACTIVE_B    = 16'h2602;

   localparam logic [15:0] RESET_SELECT_A  = 16'h0000;
   localparam logic [15:0] RESET_SELECT_B  = 16'h0100;

   localparam logic [3:0]  CODE_DISABLED   = 4'h0;
   localparam logic [3:0]  CODE_PAIR1      = 4'h1;
   localparam logic [3:0]  CODE_PAIR2      = 4'h2;
   localparam logic [3:0]  CODE_PAIR3      = 4'h3;

   localparam int          POS_FIELD0      = 0;
   localparam int          POS_FIELD1      = 4;
   localparam int          POS_FIELD2      = 8;
   localparam int          POS_FIELD3      = 12;

   // Internal drive indications, high when asserted
   typedef struct packed {
      logic warning;
      logic brake_release;
      logic speed_limited;
      logic torque_limited;
      logic servo_ready;
      logic rotating;
      logic speed_match;
      logic position_done;
   } status_ind_t;

   typedef struct packed {
      logic [DATA_W-1:0] stored_a;
      logic [DATA_W-1:0] stored_b;
      logic [DATA_W-1:0] active_a;
      logic [DATA_W-1:0] active_b;
      logic [DATA_W-1:0] rd_data;
      logic [PAIR_N-1:0] pair_out;
   } router_state_t;

   // Pair select bit for one field code; reserved codes select nothing
   function automatic logic [PAIR_N-1:0] code_to_pairs(input logic [FIELD_W-1:0] code);
      unique case (code)
         CODE_PAIR1: code_to_pairs = 3'h1;
         CODE_PAIR2: code_to_pairs = 3'h2;
         CODE_PAIR3: code_to_pairs = 3'h4;
         default:    code_to_pairs = 3'h0;
      endcase
   endfunction

endpackage

// ---- router_word_decoder.sv ----
// Purpose: Decode one selection word into pair drive terms
// Assumes: Four 4-bit fields, each routing one indication
// Notes:   Purely combinational
`timescale 1ns/1ps
module router_word_decoder
   import status_router_pkg::*;
(
   input  wire logic [DATA_W-1:0]  select_word,
   input  wire logic [FIELD_N-1:0] ind,
   output logic      [PAIR_N-1:0]  pair_drive
);

   logic [PAIR_N-1:0] hit0;
   logic [PAIR_N-1:0] hit1;
   logic [PAIR_N-1:0] hit2;
   logic [PAIR_N-1:0] hit3;

   always_comb begin
      // Field code to pair, code 0 and reserved codes drive nothing
      hit0 = ind[0] ? code_to_pairs(select_word[POS_FIELD0 +: FIELD_W]) : 3'h0;
      hit1 = ind[1] ? code_to_pairs(select_word[POS_FIELD1 +: FIELD_W]) : 3'h0;
      hit2 = ind[2] ? code_to_pairs(select_word[POS_FIELD2 +: FIELD_W]) : 3'h0;
      hit3 = ind[3] ? code_to_pairs(select_word[POS_FIELD3 +: FIELD_W]) : 3'h0;
      // Shared pairs merge by OR
      pair_drive = hit0 | hit1 | hit2 | hit3;
   end

endmodule

// ---- relay_reader.sv ----
// Purpose: Far-side reader of the three output pairs
// Assumes: Relay inputs latch the terminals on core_clk
// Notes:   Holds last sampled levels for the bench
`timescale 1ns/1ps
module relay_reader
   import status_router_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic [PAIR_N-1:0] terminals,
   output logic      [PAIR_N-1:0] seen
);
   ////////////////////////////////////////////////////////////////////////
   // Sample terminal levels
   always_ff @(posedge core_clk) begin
      seen <= terminals;
   end
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the status output router
// Assumes: Register port with one-cycle read answer
// Notes:   Routing table swept over all indications and codes 0 to 3
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
   import status_router_pkg::*;
   logic              core_clk;
   logic              reset_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_write;
   logic              reg_read;
   logic [DATA_W-1:0] reg_rdata;
   logic              restart_pulse;
   status_ind_t       status_ind;
   logic [PAIR_N-1:0] io_connector;
   logic [PAIR_N-1:0] seen;
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] wa;
   logic [DATA_W-1:0] wb;
   logic [PAIR_N-1:0] ep;
   int                err_count;
   int                checks;

   status_output_router dut (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .reg_addr     (reg_addr),
      .reg_wdata    (reg_wdata),
      .reg_write    (reg_write),
      .reg_read     (reg_read),
      .reg_rdata    (reg_rdata),
      .restart_pulse(restart_pulse),
      .status_ind   (status_ind),
      .io_connector (io_connector)
   );
   relay_reader far (
      .core_clk (core_clk),
      .terminals(io_connector),
      .seen     (seen)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      err_count++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus tasks
   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic reg_rd(input logic [ADDR_W-1:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(posedge core_clk);
      rd = reg_rdata;
   endtask
   task automatic restart();
      restart_pulse <= 1'b1;
      @(posedge core_clk);
      restart_pulse <= 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(posedge core_clk);
   endtask
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      err_count     = 0;
      checks        = 0;
      reset_n       = 1'b0;
      reg_addr      = 16'h0000;
      reg_wdata     = 16'h0000;
      reg_write     = 1'b0;
      reg_read      = 1'b0;
      restart_pulse = 1'b0;
      status_ind    = status_ind_t'(8'h00);
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      reg_rd(OFS_SELECT_A);
      `CHK("select_a reset", 16'h0000, rd)
      reg_rd(OFS_SELECT_B);
      `CHK("select_b reset", 16'h0100, rd)
      @(posedge core_clk);
      `CHK("rdata after answer", 16'h0000, reg_rdata)
      status_ind <= status_ind_t'(8'h40);
      settle();
      `CHK("brake default pair", 3'h1, seen)
      status_ind <= status_ind_t'(8'h01);
      reg_wr(OFS_SELECT_A, 16'h0001);
      reg_wr(16'h1234, 16'hffff);
      reg_wr(OFS_ACTIVE_A, 16'h0003);
      settle();
      `CHK("no restart", 3'h0, seen)
      reg_rd(OFS_SELECT_A);
      `CHK("stored a", 16'h0001, rd)
      reg_rd(16'h1234);
      `CHK("unmapped read", 16'h0000, rd)
      reg_rd(OFS_ACTIVE_A);
      `CHK("active a untouched", 16'h0000, rd)
      reg_wr(OFS_SELECT_A, 16'h0004);
      reg_wr(OFS_SELECT_B, 16'h0000);
      restart();
      settle();
      `CHK("reserved code", 3'h0, seen)
      for (int i = 0; i < 8; i++) begin
         for (int c = 0; c < 4; c++) begin
            wa = (i < 4) ? (16'(c) << (4 * i)) : 16'h0000;
            wb = (i >= 4) ? (16'(c) << (4 * (i - 4))) : 16'h0000;
            ep = (c == 0) ? 3'h0 : 3'(1 << (c - 1));
            reg_wr(OFS_SELECT_A, wa);
            reg_wr(OFS_SELECT_B, wb);
            restart();
            status_ind <= status_ind_t'(8'h01 << i);
            settle();
            `CHK("routed pair", ep, seen)
            status_ind <= status_ind_t'(8'h00);
            settle();
            `CHK("indication off", 3'h0, seen)
         end
      end
      reg_wr(OFS_SELECT_A, 16'h0321);
      reg_wr(OFS_SELECT_B, 16'h0000);
      reg_rd(OFS_PENDING);
      `CHK("pending set", 16'h0001, rd)
      restart();
      reg_rd(OFS_PENDING);
      `CHK("pending clear", 16'h0000, rd)
      reg_rd(OFS_ACTIVE_A);
      `CHK("active a", 16'h0321, rd)
      reg_rd(OFS_ACTIVE_B);
      `CHK("active b", 16'h0000, rd)
      status_ind <= status_ind_t'(8'h07);
      settle();
      `CHK("three pairs", 3'h7, seen)
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      reg_rd(OFS_SELECT_A);
      `CHK("select_a after reset", 16'h0000, rd)
      reg_rd(OFS_ACTIVE_B);
      `CHK("active_b after reset", 16'h0100, rd)
      status_ind <= status_ind_t'(8'h40);
      settle();
      `CHK("brake after reset", 3'h1, seen)
      conclude();
   end
endmodule
